// ---- core/strap_cfg_pkg.sv ----
// Shared constants and types of the reset strap configuration block
package strap_cfg_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_STRAP_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_POLARITY = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_BYTE_ORDER = 0;
    localparam int BIT_HOST_WIDTH = 1;
    localparam int BIT_PCI_EN = 2;
    localparam int BIT_AUTOINIT = 3;
    localparam int LSB_BOOT = 4;
    localparam int LSB_CLKSEL = 6;
    localparam int BIT_BOOT_BAD = 8;
    localparam int BIT_CLK_BAD = 9;
    localparam int BIT_CFG_VALID = 10;
    localparam int LSB_EXT_IRQ = 0;
    localparam int BIT_NMI = 4;
    localparam int EXT_IRQ_N = 4;
    localparam int IRQ_W = 5;
    localparam int HOST_DATA_W = 32;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] BOOT_NONE = 2'h0;
    localparam logic [1:0] BOOT_HOST = 2'h1;
    localparam logic [1:0] BOOT_RSVD = 2'h2;
    localparam logic [1:0] BOOT_ROM8 = 2'h3;
    localparam logic [1:0] CLK_INPUT = 2'h0;
    localparam logic [1:0] CLK_DIV4 = 2'h1;
    localparam logic [1:0] CLK_DIV6 = 2'h2;
    localparam logic [1:0] CLK_RSVD = 2'h3;
    localparam logic [2:0] DIV4_LAST = 3'h3;
    localparam logic [2:0] DIV6_LAST = 3'h5;
    localparam logic [31:0] LOW_HALF_OE = 32'h0000FFFF;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 5'h00;
    localparam logic [EXT_IRQ_N-1:0] RST_IRQ_ENABLE = 4'h0;
    localparam logic [EXT_IRQ_N-1:0] RST_IRQ_POLARITY = 4'h0;

    typedef enum logic {
        ST_CAPTURE,
        ST_RUN
    } cfg_state_t;

endpackage

// ---- core/reset_strap_config.sv ----
// Reset strap capture, decoded configuration, NMI and external interrupt pins
`timescale 1ns/1ps

module reset_strap_config (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic BYTE_ORDER_STRAP,
    input wire logic HOST_DATA_BIT5_STRAP,
    input wire logic PCI_ENABLE_STRAP,
    input wire logic EEPROM_AUTOINIT_STRAP,
    input wire logic [1:0] BOOT_MODE_STRAP,
    input wire logic [1:0] EXTMEM_CLOCK_SELECT_STRAP,
    input wire logic EXTMEM_CLOCK_INPUT,
    input wire logic [strap_cfg_pkg::HOST_DATA_W-1:0] HOST_DATA_LINES_OE_REQ,
    input wire logic NMI_IN,
    input wire logic [strap_cfg_pkg::EXT_IRQ_N-1:0] EXTERNAL_IRQ_PIN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [strap_cfg_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic CONFIG_VALID,
    output logic BYTE_ORDER_LITTLE,
    output logic HOST_PORT_WIDTH_32,
    output logic HOST_PORT_EN,
    output logic GENERAL_PURPOSE_PIN_HI_EN,
    output logic PCI_PERIPH_EN,
    output logic EEPROM_AUTOINIT_EN,
    output logic BOOT_NO_BOOT,
    output logic BOOT_HOST_PORT,
    output logic BOOT_EXT_ROM8,
    output logic BOOT_MODE_INVALID,
    output logic EXTMEM_CLK_FROM_INPUT,
    output logic EXTMEM_CLK_EN,
    output logic EXTMEM_CLK_SEL_INVALID,
    output logic [strap_cfg_pkg::HOST_DATA_W-1:0] HOST_DATA_LINES_OE,
    output logic NMI_REQ,
    output logic [strap_cfg_pkg::EXT_IRQ_N-1:0] EXT_IRQ_REQ,
    output logic IRQ
);
    import strap_cfg_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        cfg_state_t state;
        logic byte_order;
        logic host32;
        logic pci_en;
        logic autoinit;
        logic [1:0] boot;
        logic [1:0] clksel;
        logic cfg_valid;
        logic little;
        logic width32;
        logic host_en;
        logic gen_pin_hi_en;
        logic pci_out;
        logic autoinit_out;
        logic boot_none;
        logic boot_host;
        logic boot_rom8;
        logic boot_bad;
        logic clk_input;
        logic clk_bad;
        logic [2:0] div_cnt;
        logic ext_clk_prev;
        logic clk_en;
        logic [HOST_DATA_W-1:0] host_oe;
        logic nmi_prev;
        logic nmi_req;
        logic [EXT_IRQ_N-1:0] pin_prev;
        logic [EXT_IRQ_N-1:0] ext_req;
        logic [EXT_IRQ_N-1:0] irq_en;
        logic [EXT_IRQ_N-1:0] pol;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    logic apb_setup;
    logic apb_write;
    logic lane0;
    logic [IRQ_W-1:0] events;
    logic [EXT_IRQ_N-1:0] edge_hit;
    logic [31:0] strap_word;

    always_comb begin
        state_nxt = state_r;
        events = '0;
        edge_hit = '0;
        strap_word = '0;
        apb_setup = PSEL & ~PENABLE;
        apb_write = PSEL & PENABLE & state_r.pready & PWRITE & ~state_r.pslverr;
        lane0 = PSTRB[0];

        // ------------------------------------------------------------
        // Strap capture
        // ------------------------------------------------------------
        // Async reset may only load constants, so straps are taken at the
        // first edge after release; board must hold them through that edge.
        case (state_r.state)
            ST_CAPTURE: begin
                state_nxt.byte_order = BYTE_ORDER_STRAP;
                state_nxt.host32 = HOST_DATA_BIT5_STRAP;
                state_nxt.pci_en = PCI_ENABLE_STRAP;
                state_nxt.autoinit = EEPROM_AUTOINIT_STRAP;
                state_nxt.boot = BOOT_MODE_STRAP;
                state_nxt.clksel = EXTMEM_CLOCK_SELECT_STRAP;
                state_nxt.state = ST_RUN;
            end
            ST_RUN: begin
                state_nxt.state = ST_RUN;
            end
            default: begin
                state_nxt.state = ST_CAPTURE;
            end
        endcase
        state_nxt.cfg_valid = (state_nxt.state == ST_RUN);

        // ------------------------------------------------------------
        // Decoded configuration
        // ------------------------------------------------------------
        state_nxt.little = state_nxt.byte_order;
        state_nxt.width32 = state_nxt.host32;
        state_nxt.host_en = state_nxt.cfg_valid & ~state_nxt.pci_en;
        state_nxt.gen_pin_hi_en = state_nxt.cfg_valid & ~state_nxt.pci_en;
        state_nxt.pci_out = state_nxt.cfg_valid & state_nxt.pci_en;
        // Gated by PCI enable so a misstrapped board cannot start the loader
        state_nxt.autoinit_out = state_nxt.cfg_valid & state_nxt.autoinit
            & state_nxt.pci_en;
        state_nxt.boot_none = state_nxt.cfg_valid & (state_nxt.boot == BOOT_NONE);
        state_nxt.boot_host = state_nxt.cfg_valid & (state_nxt.boot == BOOT_HOST);
        state_nxt.boot_rom8 = state_nxt.cfg_valid & (state_nxt.boot == BOOT_ROM8);
        state_nxt.boot_bad = state_nxt.cfg_valid & (state_nxt.boot == BOOT_RSVD);
        state_nxt.clk_input = state_nxt.cfg_valid & (state_nxt.clksel == CLK_INPUT);
        state_nxt.clk_bad = state_nxt.cfg_valid & (state_nxt.clksel == CLK_RSVD);

        // ------------------------------------------------------------
        // Host data line enables
        // ------------------------------------------------------------
        if (state_nxt.host_en && state_nxt.host32) begin
            state_nxt.host_oe = HOST_DATA_LINES_OE_REQ;
        end else if (state_nxt.host_en) begin
            state_nxt.host_oe = HOST_DATA_LINES_OE_REQ & LOW_HALF_OE;
        end else begin
            state_nxt.host_oe = '0;
        end

        // ------------------------------------------------------------
        // External memory clock enable
        // ------------------------------------------------------------
        state_nxt.ext_clk_prev = EXTMEM_CLOCK_INPUT;
        state_nxt.clk_en = 1'b0;
        state_nxt.div_cnt = '0;
        if (state_r.state == ST_RUN) begin
            case (state_r.clksel)
                CLK_INPUT: begin
                    state_nxt.clk_en = EXTMEM_CLOCK_INPUT & ~state_r.ext_clk_prev;
                end
                CLK_DIV4: begin
                    state_nxt.clk_en = (state_r.div_cnt == DIV4_LAST);
                    state_nxt.div_cnt = (state_r.div_cnt == DIV4_LAST) ? 3'h0
                        : state_r.div_cnt + 3'h1;
                end
                CLK_DIV6: begin
                    state_nxt.clk_en = (state_r.div_cnt == DIV6_LAST);
                    state_nxt.div_cnt = (state_r.div_cnt == DIV6_LAST) ? 3'h0
                        : state_r.div_cnt + 3'h1;
                end
                default: begin
                    // Reserved code: memory interface gets no clock at all
                    state_nxt.clk_en = 1'b0;
                end
            endcase
        end

        // ------------------------------------------------------------
        // Interrupt pins
        // ------------------------------------------------------------
        state_nxt.nmi_prev = NMI_IN;
        state_nxt.nmi_req = NMI_IN & ~state_r.nmi_prev;
        state_nxt.pin_prev = EXTERNAL_IRQ_PIN;
        for (int i = 0; i < EXT_IRQ_N; i++) begin
            // Polarity 0 rising, 1 falling
            edge_hit[i] = state_r.pol[i] ? (state_r.pin_prev[i] & ~EXTERNAL_IRQ_PIN[i])
                : (~state_r.pin_prev[i] & EXTERNAL_IRQ_PIN[i]);
        end
        state_nxt.ext_req = edge_hit & state_r.irq_en;
        events[LSB_EXT_IRQ +: EXT_IRQ_N] = state_nxt.ext_req;
        events[BIT_NMI] = state_nxt.nmi_req;

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        state_nxt.status = state_r.status;
        if (apb_write && lane0) begin
            case (PADDR)
                OFS_IRQ_STATUS: begin
                    state_nxt.status = state_r.status & ~PWDATA[IRQ_W-1:0];
                end
                OFS_IRQ_MASK: begin
                    state_nxt.mask = PWDATA[IRQ_W-1:0];
                end
                OFS_IRQ_ENABLE: begin
                    state_nxt.irq_en = PWDATA[EXT_IRQ_N-1:0];
                end
                OFS_IRQ_POLARITY: begin
                    state_nxt.pol = PWDATA[EXT_IRQ_N-1:0];
                end
                default: begin
                    state_nxt.mask = state_r.mask;
                end
            endcase
        end
        // Set after clear so a same-cycle event survives
        state_nxt.status = state_nxt.status | events;
        state_nxt.irq = |(state_nxt.status & state_nxt.mask);

        // ------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------
        strap_word[BIT_BYTE_ORDER] = state_r.byte_order;
        strap_word[BIT_HOST_WIDTH] = state_r.host32;
        strap_word[BIT_PCI_EN] = state_r.pci_en;
        strap_word[BIT_AUTOINIT] = state_r.autoinit;
        strap_word[LSB_BOOT +: 2] = state_r.boot;
        strap_word[LSB_CLKSEL +: 2] = state_r.clksel;
        strap_word[BIT_BOOT_BAD] = state_r.boot_bad;
        strap_word[BIT_CLK_BAD] = state_r.clk_bad;
        strap_word[BIT_CFG_VALID] = state_r.cfg_valid;

        // Zero wait states: answer prepared in setup, ready in access
        state_nxt.pready = apb_setup;
        if (apb_setup) begin
            state_nxt.pslverr = 1'b0;
            state_nxt.prdata = '0;
            case (PADDR)
                OFS_STRAP_STATUS: begin
                    state_nxt.prdata = strap_word;
                end
                OFS_IRQ_STATUS: begin
                    state_nxt.prdata[IRQ_W-1:0] = state_r.status;
                end
                OFS_IRQ_MASK: begin
                    state_nxt.prdata[IRQ_W-1:0] = state_r.mask;
                end
                OFS_IRQ_ENABLE: begin
                    state_nxt.prdata[EXT_IRQ_N-1:0] = state_r.irq_en;
                end
                OFS_IRQ_POLARITY: begin
                    state_nxt.prdata[EXT_IRQ_N-1:0] = state_r.pol;
                end
                OFS_PIN_LEVEL: begin
                    // Shared pins stay readable as inputs in either mode
                    state_nxt.prdata[EXT_IRQ_N-1:0] = state_r.pin_prev;
                end
                default: begin
                    state_nxt.pslverr = 1'b1;
                end
            endcase
        end else begin
            // Error is a one-cycle pulse beside PREADY, straight from a flop
            state_nxt.pslverr = 1'b0;
            if (!PSEL) begin
                state_nxt.prdata = '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state_r <= '0;
            state_r.state <= ST_CAPTURE;
            state_r.byte_order <= 1'b1;
            // High so a pin already high at release is no edge
            state_r.nmi_prev <= 1'b1;
            state_r.irq_en <= RST_IRQ_ENABLE;
            state_r.pol <= RST_IRQ_POLARITY;
            state_r.mask <= RST_IRQ_MASK;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Plain flop copies, no gating on the way out
    assign PRDATA = state_r.prdata;
    assign PREADY = state_r.pready;
    assign PSLVERR = state_r.pslverr;
    assign CONFIG_VALID = state_r.cfg_valid;
    assign BYTE_ORDER_LITTLE = state_r.little;
    assign HOST_PORT_WIDTH_32 = state_r.width32;
    assign HOST_PORT_EN = state_r.host_en;
    assign GENERAL_PURPOSE_PIN_HI_EN = state_r.gen_pin_hi_en;
    assign PCI_PERIPH_EN = state_r.pci_out;
    assign EEPROM_AUTOINIT_EN = state_r.autoinit_out;
    assign BOOT_NO_BOOT = state_r.boot_none;
    assign BOOT_HOST_PORT = state_r.boot_host;
    assign BOOT_EXT_ROM8 = state_r.boot_rom8;
    assign BOOT_MODE_INVALID = state_r.boot_bad;
    assign EXTMEM_CLK_FROM_INPUT = state_r.clk_input;
    assign EXTMEM_CLK_EN = state_r.clk_en;
    assign EXTMEM_CLK_SEL_INVALID = state_r.clk_bad;
    assign HOST_DATA_LINES_OE = state_r.host_oe;
    assign NMI_REQ = state_r.nmi_req;
    assign EXT_IRQ_REQ = state_r.ext_req;
    assign IRQ = state_r.irq;

endmodule

// ---- testbench/strap_board.sv ----
// Board strap resistor network feeding the configuration pins
`timescale 1ns/1ps
module strap_board (
    input wire logic [7:0] want,
    input wire logic rogue,
    output logic BYTE_ORDER_STRAP,
    output logic HOST_DATA_BIT5_STRAP,
    output logic PCI_ENABLE_STRAP,
    output logic EEPROM_AUTOINIT_STRAP,
    output logic [1:0] BOOT_MODE_STRAP,
    output logic [1:0] EXTMEM_CLOCK_SELECT_STRAP
);
    // ------------------------------------------------------------
    // Pull network
    // ------------------------------------------------------------
    always_comb begin
        {EXTMEM_CLOCK_SELECT_STRAP, BOOT_MODE_STRAP} = want[7:4];
        {PCI_ENABLE_STRAP, HOST_DATA_BIT5_STRAP, BYTE_ORDER_STRAP} = want[2:0];
        // Autoinit kept low while PCI is off
        EEPROM_AUTOINIT_STRAP = want[3] & want[2];
        // Reserved internal default overridden, unless a faulty board is modelled
        if (want[5:4] == 2'h2 && !rogue) begin
            BOOT_MODE_STRAP = 2'h3;
        end
    end
endmodule

// ---- testbench/reset_strap_config_chk.sv ----
// Port-level assertions for the reset strap configuration block
`timescale 1ns/1ps
module reset_strap_config_chk (
    input wire logic REF_CLK, NRST, BYTE_ORDER_STRAP, HOST_DATA_BIT5_STRAP, PCI_ENABLE_STRAP,
    input wire logic [1:0] EXTMEM_CLOCK_SELECT_STRAP,
    input wire logic NMI_IN, PSEL, PENABLE, PWRITE, PREADY,
    input wire logic [strap_cfg_pkg::EXT_IRQ_N-1:0] EXTERNAL_IRQ_PIN, EXT_IRQ_REQ,
    input wire logic [strap_cfg_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic CONFIG_VALID, BYTE_ORDER_LITTLE, HOST_PORT_WIDTH_32, HOST_PORT_EN,
    input wire logic GENERAL_PURPOSE_PIN_HI_EN, PCI_PERIPH_EN, EEPROM_AUTOINIT_EN,
    input wire logic BOOT_NO_BOOT, BOOT_HOST_PORT, BOOT_EXT_ROM8, BOOT_MODE_INVALID,
    input wire logic EXTMEM_CLK_EN, NMI_REQ,
    input wire logic [strap_cfg_pkg::HOST_DATA_W-1:0] HOST_DATA_LINES_OE
);
    import strap_cfg_pkg::*;
    logic [4:0] cfg_q;
    logic [3:0] en_q, pol_q, pin_q, hit;
    logic wr_ok;
    // ------------------------------------------------------------
    // Mirrors of captured straps and interrupt settings
    // ------------------------------------------------------------
    // Loads until valid rises, so it freezes on the same edge as the capture
    always_ff @(posedge REF_CLK) begin
        if (!CONFIG_VALID)
            cfg_q <= {EXTMEM_CLOCK_SELECT_STRAP, PCI_ENABLE_STRAP, HOST_DATA_BIT5_STRAP,
                      BYTE_ORDER_STRAP};
    end
    assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
    assign hit = en_q & (EXTERNAL_IRQ_PIN ^ pin_q) & (EXTERNAL_IRQ_PIN ^ pol_q);
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            en_q <= 4'h0;
            pol_q <= 4'h0;
            pin_q <= 4'h0;
        end else begin
            pin_q <= EXTERNAL_IRQ_PIN;
            if (wr_ok && PADDR == OFS_IRQ_ENABLE)
                en_q <= PWDATA[3:0];
            if (wr_ok && PADDR == OFS_IRQ_POLARITY)
                pol_q <= PWDATA[3:0];
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    property p_cfg; CONFIG_VALID |->
        {PCI_PERIPH_EN, HOST_PORT_WIDTH_32, BYTE_ORDER_LITTLE} == cfg_q[2:0]; endproperty
    a_cfg: assert property (p_cfg) else $error("captured strap mismatch");
    property p_sel; CONFIG_VALID |->
        HOST_PORT_EN == !PCI_PERIPH_EN && GENERAL_PURPOSE_PIN_HI_EN == HOST_PORT_EN; endproperty
    a_sel: assert property (p_sel) else $error("host or pci select wrong");
    property p_auto; EEPROM_AUTOINIT_EN |-> PCI_PERIPH_EN; endproperty
    a_auto: assert property (p_auto) else $error("autoinit without pci");
    property p_boot; CONFIG_VALID |->
        $onehot({BOOT_NO_BOOT, BOOT_HOST_PORT, BOOT_EXT_ROM8, BOOT_MODE_INVALID}); endproperty
    a_boot: assert property (p_boot) else $error("boot decode not one-hot");
    property p_w16; !HOST_PORT_WIDTH_32 |-> HOST_DATA_LINES_OE[31:16] == 16'h0000; endproperty
    a_w16: assert property (p_w16) else $error("upper lines driven in 16-bit");
    property p_div4; CONFIG_VALID && cfg_q[4:3] == CLK_DIV4 && EXTMEM_CLK_EN
        |=> !EXTMEM_CLK_EN [*3] ##1 EXTMEM_CLK_EN; endproperty
    a_div4: assert property (p_div4) else $error("divide by four period wrong");
    property p_div6; CONFIG_VALID && cfg_q[4:3] == CLK_DIV6 && EXTMEM_CLK_EN
        |=> !EXTMEM_CLK_EN [*5] ##1 EXTMEM_CLK_EN; endproperty
    a_div6: assert property (p_div6) else $error("divide by six period wrong");
    property p_rsv; CONFIG_VALID && cfg_q[4:3] == CLK_RSVD |-> !EXTMEM_CLK_EN; endproperty
    a_rsv: assert property (p_rsv) else $error("clock pulse in reserved mode");
    property p_nmi; NMI_REQ |-> $past(NMI_IN) && !$past(NMI_IN, 2); endproperty
    a_nmi: assert property (p_nmi) else $error("nmi request without rising edge");
    property p_nmi2; CONFIG_VALID && $rose(NMI_IN) |=> NMI_REQ; endproperty
    a_nmi2: assert property (p_nmi2) else $error("nmi rising edge missed");
    property p_ext; CONFIG_VALID |=> EXT_IRQ_REQ == $past(hit); endproperty
    a_ext: assert property (p_ext) else $error("external interrupt edge wrong");
endmodule
bind reset_strap_config reset_strap_config_chk chk_i (.*);

// ---- testbench/tb.sv ----
// Self-checking bench for the reset strap configuration block
`timescale 1ns/1ps
module tb;
    import strap_cfg_pkg::*;
    logic REF_CLK = 1'b0, NRST = 1'b0, EXTMEM_CLOCK_INPUT = 1'b0, NMI_IN = 1'b0, rerr, rdy;
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, rogue = 1'b0;
    logic [ADDR_W-1:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, HOST_DATA_LINES_OE_REQ = 32'h0, rdat, nx;
    logic [3:0] PSTRB = 4'hF, EXTERNAL_IRQ_PIN = 4'h0, EXT_IRQ_REQ, e, p;
    logic [7:0] want = 8'h00, s, cap;
    logic [1:0] BOOT_MODE_STRAP, EXTMEM_CLOCK_SELECT_STRAP;
    logic BYTE_ORDER_STRAP, HOST_DATA_BIT5_STRAP, PCI_ENABLE_STRAP, EEPROM_AUTOINIT_STRAP;
    logic [31:0] PRDATA, HOST_DATA_LINES_OE;
    logic PREADY, PSLVERR, CONFIG_VALID, BYTE_ORDER_LITTLE, HOST_PORT_WIDTH_32, HOST_PORT_EN;
    logic GENERAL_PURPOSE_PIN_HI_EN, PCI_PERIPH_EN, EEPROM_AUTOINIT_EN, BOOT_NO_BOOT;
    logic BOOT_HOST_PORT, BOOT_EXT_ROM8, BOOT_MODE_INVALID, EXTMEM_CLK_FROM_INPUT;
    logic EXTMEM_CLK_EN, EXTMEM_CLK_SEL_INVALID, NMI_REQ, IRQ;
    logic [12:0] outs;
    int fail_count = 0, tests_run = 0, cyc = 0, n, seed = 15;
    assign s = {EXTMEM_CLOCK_SELECT_STRAP, BOOT_MODE_STRAP, EEPROM_AUTOINIT_STRAP,
                PCI_ENABLE_STRAP, HOST_DATA_BIT5_STRAP, BYTE_ORDER_STRAP};
    assign outs = {BYTE_ORDER_LITTLE, HOST_PORT_WIDTH_32, PCI_PERIPH_EN, HOST_PORT_EN,
                   GENERAL_PURPOSE_PIN_HI_EN, EEPROM_AUTOINIT_EN, BOOT_EXT_ROM8,
                   BOOT_MODE_INVALID, BOOT_HOST_PORT, BOOT_NO_BOOT, EXTMEM_CLK_SEL_INVALID,
                   EXTMEM_CLK_FROM_INPUT, CONFIG_VALID};
    reset_strap_config DUT (.*);
    strap_board board (.*);
    // ------------------------------------------------------------
    // Expectations and bus tasks
    // ------------------------------------------------------------
    function automatic logic [12:0] exp_out(input logic [7:0] c);
        return {c[0], c[1], c[2], !c[2], !c[2], c[3] & c[2], 4'h1 << c[5:4],
                c[7:6] == 2'h3, c[7:6] == 2'h0, 1'b1};
    endfunction
    function automatic logic [31:0] exp_stat(input logic [7:0] c);
        return {21'h0, 1'b1, c[7:6] == 2'h3, c[5:4] == 2'h2, c};
    endfunction
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Waits for PREADY with no fixed latency; only the cycle ceiling ends a hang
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        // Answer read where it has settled, half a cycle before the edge that takes it
        do begin
            @(negedge REF_CLK);
            rdy = PREADY;
            rdat = PRDATA;
            rerr = PSLVERR;
            @(posedge REF_CLK);
        end while (rdy !== 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task close_out;
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        forever #4 REF_CLK = ~REF_CLK;
    end
    // Memory clock input of period six cycles; ceiling far above the run length
    always @(posedge REF_CLK) begin
        cyc <= cyc + 1;
        EXTMEM_CLOCK_INPUT <= (cyc % 6) < 3;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        for (int k = 0; k < 6; k++) begin
            nx = $random(seed);
            @(posedge REF_CLK);
            NRST <= 1'b0;
            want <= k < 4 ? {k[1:0], k[1:0], nx[3:0]} : nx[7:0];
            rogue <= k == 2;
            repeat (2) @(posedge REF_CLK);
            NRST <= 1'b1;
            repeat (4) @(posedge REF_CLK);
            cap = s;
            chk("decoded outputs", outs, exp_out(cap));
            apb(1'b0, OFS_STRAP_STATUS, 32'h0);
            chk("strap status", rdat, exp_stat(cap));
            want <= ~want;
            HOST_DATA_LINES_OE_REQ <= $random(seed);
            n = 0;
            repeat (24) begin
                @(negedge REF_CLK);
                if (EXTMEM_CLK_EN === 1'b1) n++;
            end
            chk("clock pulses", n, cap[7:6] == 2'h3 ? 0 : (cap[7:6] == 2'h1 ? 6 : 4));
            chk("held outputs", outs, exp_out(cap));
            nx = cap[2] ? 32'h0 : HOST_DATA_LINES_OE_REQ & (cap[1] ? 32'hFFFFFFFF : LOW_HALF_OE);
            chk("line enables", HOST_DATA_LINES_OE, nx);
        end
        apb(1'b0, OFS_IRQ_ENABLE, 32'h0);
        chk("enable reset", rdat, 32'h0);
        EXTERNAL_IRQ_PIN <= 4'hF;
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("input only", rdat, 32'h0);
        apb(1'b0, OFS_PIN_LEVEL, 32'h0);
        chk("pin level", rdat, 32'hF);
        EXTERNAL_IRQ_PIN <= 4'h0;
        e = 4'($random(seed));
        p = 4'($random(seed));
        apb(1'b1, OFS_IRQ_ENABLE, {28'h0, e});
        apb(1'b1, OFS_IRQ_POLARITY, {28'h0, p});
        PSTRB <= 4'hE;
        apb(1'b1, OFS_IRQ_POLARITY, {28'h0, ~p});
        PSTRB <= 4'hF;
        apb(1'b0, OFS_IRQ_POLARITY, 32'h0);
        chk("lane zero off", rdat, {28'h0, p});
        EXTERNAL_IRQ_PIN <= 4'hF;
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("rising edges", rdat, {28'h0, e & ~p});
        chk("masked irq", IRQ, 1'b0);
        apb(1'b1, OFS_IRQ_MASK, 32'h1F);
        @(negedge REF_CLK);
        chk("irq line", IRQ, |(e & ~p));
        apb(1'b1, OFS_IRQ_STATUS, 32'h1F);
        EXTERNAL_IRQ_PIN <= 4'h0;
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("falling edges", rdat, {28'h0, e & p});
        apb(1'b1, OFS_IRQ_STATUS, 32'h1F);
        NMI_IN <= 1'b1;
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("nmi edge", rdat, 32'h10);
        apb(1'b1, OFS_IRQ_STATUS, 32'h1F);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("nmi level", rdat, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", rerr, 1'b1);
        close_out();
    end
endmodule
